// [hdl/notice_pkg.sv]
// Constants for the predictive notice monitor
package notice_pkg;
    // Notice indices
    localparam int N_NOTICE = 11;
    localparam int IDX_WATCH = 0;
    localparam int IDX_DEV = 1;
    localparam int IDX_DRV_HEAT = 2;
    localparam int IDX_MTR_HEAT = 3;
    localparam int IDX_HIGH_SUP = 4;
    localparam int IDX_LOW_SUP = 5;
    localparam int IDX_OVL_TIME = 6;
    localparam int IDX_SPEED = 7;
    localparam int IDX_LOAD_A = 8;
    localparam int IDX_LOAD_B = 9;
    localparam int IDX_TRIP = 10;
    // Register offsets (byte addresses)
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACTION = 8'h04;
    localparam logic [7:0] REG_WATCH = 8'h08;
    localparam logic [7:0] REG_DEV_TH = 8'h0c;
    localparam logic [7:0] REG_DRV_TH = 8'h10;
    localparam logic [7:0] REG_MTR_TH = 8'h14;
    localparam logic [7:0] REG_HIGH_TH = 8'h18;
    localparam logic [7:0] REG_LOW_TH = 8'h1c;
    localparam logic [7:0] REG_OVL_TH = 8'h20;
    localparam logic [7:0] REG_SPD_TH = 8'h24;
    localparam logic [7:0] REG_LOAD_A_TH = 8'h28;
    localparam logic [7:0] REG_LOAD_B_TH = 8'h2c;
    localparam logic [7:0] REG_DIVISOR = 8'h30;
    localparam logic [7:0] REG_TRIP_TH = 8'h34;
    localparam logic [7:0] REG_STATUS = 8'h38;
    localparam logic [7:0] REG_LOAD_SUM = 8'h3c;
    localparam logic [7:0] REG_CLEAR = 8'h40;
    // Control and watch field positions
    localparam int CTRL_AUTO_CLR = 0;
    localparam int CTRL_LED_EN = 1;
    localparam int CTRL_LOAD_CLR = 2;
    localparam int CTRL_AC_SUPPLY = 3;
    localparam int WATCH_INV = 8;
    // Reset values
    localparam logic [3:0] CTRL_RST = 4'hf;
    localparam logic [10:0] ACTION_RST = 11'h7ff;
    localparam logic [7:0] WATCH_SEL_RST = 8'h80;
    localparam logic [14:0] DEV_TH_RST = 15'h012c;
    localparam logic [6:0] DRV_TH_RST = 7'h55;
    localparam logic [6:0] MTR_TH_RST = 7'h55;
    localparam logic [9:0] HIGH_TH_AC_RST = 10'h1b3;
    localparam logic [9:0] LOW_TH_AC_RST = 10'h078;
    localparam logic [9:0] HIGH_TH_DC_RST = 10'h276;
    localparam logic [9:0] LOW_TH_DC_RST = 10'h0b4;
    localparam logic [8:0] OVL_TH_RST = 9'h032;
    localparam logic [13:0] SPD_TH_RST = 14'h0000;
    localparam logic [30:0] LOAD_TH_RST = 31'h0000_0000;
    localparam logic [14:0] DIVISOR_RST = 15'h0001;
    localparam logic [30:0] TRIP_TH_RST = 31'h0000_0000;
    // LED pattern timing: two blinks then a pause
    localparam int BLINK_ON_MS = 200;
    localparam int BLINK_OFF_MS = 200;
    localparam int PAUSE_MS = 1000;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_CYCLES = CLK_HZ / 1000;
    localparam int BLINK_ON_CYC = BLINK_ON_MS * MS_CYCLES;
    localparam int BLINK_OFF_CYC = BLINK_OFF_MS * MS_CYCLES;
    localparam int PAUSE_CYC = PAUSE_MS * MS_CYCLES;
    // Blink sequencer states
    typedef enum logic [2:0] {
        LED_IDLE, LED_ON1, LED_OFF1, LED_ON2, LED_PAUSE
    } led_state_t;
endpackage : notice_pkg

// [hdl/predictive_notice_monitor.sv]
// Warning-level notice monitor with flags, aggregate output and LED blink
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps

module predictive_notice_monitor
    import notice_pkg::*;
#(
    // Blink timing in clock cycles; short values suit simulation
    parameter int BLINK_ON = BLINK_ON_CYC,
    parameter int BLINK_OFF = BLINK_OFF_CYC,
    parameter int PAUSE = PAUSE_CYC,
    // Width of the watch selection code
    parameter int SEL_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Measured quantities
    input wire logic [14:0] deviation,
    input wire logic [6:0] driver_temp,
    input wire logic [6:0] motor_temp,
    input wire logic [9:0] supply_volt,
    input wire logic [8:0] overload_time,
    input wire logic [13:0] motor_speed,
    input wire logic [15:0] load_sample,
    input wire logic load_sample_vld,
    input wire logic [30:0] trip_distance,
    input wire logic motion_active,
    // Output signals open to the watch selector
    input wire logic [(1 << SEL_W)-1:0] watch_sources,
    // Notice outputs
    output logic user_watch_flag,
    output logic deviation_notice_flag,
    output logic driver_heat_notice_flag,
    output logic motor_heat_notice_flag,
    output logic high_supply_notice_flag,
    output logic low_supply_notice_flag,
    output logic overload_time_notice_flag,
    output logic speed_notice_flag,
    output logic load_sum_a_notice_flag,
    output logic load_sum_b_notice_flag,
    output logic trip_distance_notice_flag,
    output logic notice_out,
    // Twin colour indicator
    output logic twin_colour_indicator_red,
    output logic twin_colour_indicator_green
);

    // Settings
    logic [3:0] ctrl_r, ctrl_nxt;                 // Auto clear, LED, load clear, AC
    logic [10:0] action_r, action_nxt;            // Reflect bit per notice
    logic [SEL_W-1:0] watch_sel_r, watch_sel_nxt; // Watched signal code
    logic watch_inv_r, watch_inv_nxt;             // Watch inversion
    // Thresholds in the units of each measurement
    logic [14:0] dev_th_r, dev_th_nxt;
    logic [6:0] drv_th_r, drv_th_nxt;
    logic [6:0] mtr_th_r, mtr_th_nxt;
    logic [9:0] high_th_r, high_th_nxt;
    logic [9:0] low_th_r, low_th_nxt;
    logic [8:0] ovl_th_r, ovl_th_nxt;
    logic [13:0] spd_th_r, spd_th_nxt;
    // Load and travel limits; zero trip disables
    logic [30:0] load_a_th_r, load_a_th_nxt;
    logic [30:0] load_b_th_r, load_b_th_nxt;
    logic [14:0] divisor_r, divisor_nxt;
    logic [30:0] trip_th_r, trip_th_nxt;

    // Notice state
    logic [10:0] flag_r, flag_nxt;                // Held notice flags
    logic [10:0] cond;                            // Live generation conditions
    logic [30:0] load_sum_r, load_sum_nxt;        // Cumulative load
    logic [14:0] div_cnt_r, div_cnt_nxt;          // Divisor prescaler
    logic motion_d_r, motion_d_nxt;               // Motion edge detector
    logic [31:0] rdata_r, rdata_nxt;
    logic host_clear;

    // LED sequencer
    led_state_t led_st_r, led_st_nxt;
    logic [31:0] led_cnt_r, led_cnt_nxt;
    logic led_on_r, led_on_nxt;
    logic blink_req;

    // Any write to the clear address; data ignored
    assign host_clear = reg_wr && (reg_addr == REG_CLEAR);

    // Generation conditions from live measurements
    always_comb begin
        cond = '0;
        // Watch flag with optional inversion
        cond[IDX_WATCH] = watch_sources[watch_sel_r] ^ watch_inv_r;
        // Reaching a limit counts as crossing it
        cond[IDX_DEV] = deviation >= dev_th_r;
        cond[IDX_DRV_HEAT] = driver_temp >= drv_th_r;
        cond[IDX_MTR_HEAT] = motor_temp >= mtr_th_r;
        // One register pair serves both supply variants
        cond[IDX_HIGH_SUP] = supply_volt >= high_th_r;
        cond[IDX_LOW_SUP] = supply_volt <= low_th_r;
        cond[IDX_OVL_TIME] = overload_time >= ovl_th_r;
        // Zero threshold means disabled
        cond[IDX_SPEED] = (spd_th_r != '0) && (motor_speed >= spd_th_r);
        // Both load notices watch one sum
        cond[IDX_LOAD_A] = load_sum_r >= load_a_th_r;
        cond[IDX_LOAD_B] = load_sum_r >= load_b_th_r;
        cond[IDX_TRIP] = (trip_th_r != '0) && (trip_distance >= trip_th_r);
    end

    // Flag hold and clear; a live cause always wins over a clear
    always_comb begin
        // Auto clear: flags track live causes
        if (ctrl_r[CTRL_AUTO_CLR]) begin
            flag_nxt = cond;
        end else if (host_clear) begin
            // Clear drops only flags whose cause is gone
            flag_nxt = cond;
        end else begin
            // Hold: a raised flag stays until cleared
            flag_nxt = flag_r | cond;
        end
    end

    // Cumulative load with divisor and start-edge clear
    always_comb begin
        load_sum_nxt = load_sum_r;
        div_cnt_nxt = div_cnt_r;
        // Edge detector resets low, the idle level of motion
        motion_d_nxt = motion_active;
        // Start of motion clears the sum when enabled
        if (motion_active && !motion_d_r && ctrl_r[CTRL_LOAD_CLR]) begin
            load_sum_nxt = '0;
            div_cnt_nxt = '0;
        end else if (load_sample_vld) begin
            // One count per divisor samples; saturate instead of wrapping
            if (div_cnt_r + 15'h0001 >= divisor_r) begin
                div_cnt_nxt = '0;
                if (load_sum_r + 31'(load_sample) >= load_sum_r) begin
                    load_sum_nxt = load_sum_r + 31'(load_sample);
                end else begin
                    // Pinned at full scale; never wraps to small
                    load_sum_nxt = '1;
                end
            end else begin
                div_cnt_nxt = div_cnt_r + 15'h0001;
            end
        end
    end

    // Settings write port
    always_comb begin
        ctrl_nxt = ctrl_r;
        action_nxt = action_r;
        watch_sel_nxt = watch_sel_r;
        watch_inv_nxt = watch_inv_r;
        dev_th_nxt = dev_th_r;
        drv_th_nxt = drv_th_r;
        mtr_th_nxt = mtr_th_r;
        high_th_nxt = high_th_r;
        low_th_nxt = low_th_r;
        ovl_th_nxt = ovl_th_r;
        spd_th_nxt = spd_th_r;
        load_a_th_nxt = load_a_th_r;
        load_b_th_nxt = load_b_th_r;
        divisor_nxt = divisor_r;
        trip_th_nxt = trip_th_r;
        if (reg_wr) begin
            // Read-only and unmapped addresses change nothing
            unique case (reg_addr)
                REG_CTRL: ctrl_nxt = reg_wdata[3:0];
                REG_ACTION: action_nxt = reg_wdata[10:0];
                REG_WATCH: begin
                    watch_sel_nxt = reg_wdata[SEL_W-1:0];
                    watch_inv_nxt = reg_wdata[WATCH_INV];
                end
                REG_DEV_TH: dev_th_nxt = reg_wdata[14:0];
                REG_DRV_TH: drv_th_nxt = reg_wdata[6:0];
                REG_MTR_TH: mtr_th_nxt = reg_wdata[6:0];
                REG_HIGH_TH: high_th_nxt = reg_wdata[9:0];
                REG_LOW_TH: low_th_nxt = reg_wdata[9:0];
                REG_OVL_TH: ovl_th_nxt = reg_wdata[8:0];
                REG_SPD_TH: spd_th_nxt = reg_wdata[13:0];
                REG_LOAD_A_TH: load_a_th_nxt = reg_wdata[30:0];
                REG_LOAD_B_TH: load_b_th_nxt = reg_wdata[30:0];
                // A written zero divisor is stored as one, the reset value
                REG_DIVISOR: divisor_nxt = (reg_wdata[14:0] == '0) ? DIVISOR_RST : reg_wdata[14:0];
                REG_TRIP_TH: trip_th_nxt = reg_wdata[30:0];
                default: ;
            endcase
        end
    end

    // Read port, data in the following cycle only
    always_comb begin
        rdata_nxt = '0;
        // Zero outside a read slot so stale data never lingers
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CTRL: rdata_nxt = {28'h0, ctrl_r};
                REG_ACTION: rdata_nxt = {21'h0, action_r};
                REG_WATCH: rdata_nxt = {23'h0, watch_inv_r, 8'(watch_sel_r)};
                REG_DEV_TH: rdata_nxt = {17'h0, dev_th_r};
                REG_DRV_TH: rdata_nxt = {25'h0, drv_th_r};
                REG_MTR_TH: rdata_nxt = {25'h0, mtr_th_r};
                REG_HIGH_TH: rdata_nxt = {22'h0, high_th_r};
                REG_LOW_TH: rdata_nxt = {22'h0, low_th_r};
                REG_OVL_TH: rdata_nxt = {23'h0, ovl_th_r};
                REG_SPD_TH: rdata_nxt = {18'h0, spd_th_r};
                REG_LOAD_A_TH: rdata_nxt = {1'h0, load_a_th_r};
                REG_LOAD_B_TH: rdata_nxt = {1'h0, load_b_th_r};
                REG_DIVISOR: rdata_nxt = {17'h0, divisor_r};
                REG_TRIP_TH: rdata_nxt = {1'h0, trip_th_r};
                REG_STATUS: rdata_nxt = {20'h0, notice_out, flag_r};
                REG_LOAD_SUM: rdata_nxt = {1'h0, load_sum_r};
                default: rdata_nxt = '0;
            endcase
        end
    end

    // Aggregate: only reflected notices count
    assign notice_out = |(flag_r & action_r);
    assign blink_req = notice_out && ctrl_r[CTRL_LED_EN];

    // Two-blink sequencer; finishes a pattern then idles
    always_comb begin
        led_st_nxt = led_st_r;
        led_cnt_nxt = led_cnt_r + 32'h1;
        led_on_nxt = 1'b0;
        // Counter restarts at every state change
        unique case (led_st_r)
            // Dark until a reflected notice with the LED enabled
            LED_IDLE: begin
                led_cnt_nxt = '0;
                if (blink_req) begin
                    led_st_nxt = LED_ON1;
                end
            end
            // First blink lit
            LED_ON1: begin
                led_on_nxt = 1'b1;
                if (led_cnt_r >= 32'(BLINK_ON - 1)) begin
                    led_st_nxt = LED_OFF1;
                    led_cnt_nxt = '0;
                    led_on_nxt = 1'b0;
                end
            end
            // Gap between the blinks
            LED_OFF1: begin
                if (led_cnt_r >= 32'(BLINK_OFF - 1)) begin
                    led_st_nxt = LED_ON2;
                    led_cnt_nxt = '0;
                    led_on_nxt = 1'b1;
                end
            end
            // Second blink lit
            LED_ON2: begin
                led_on_nxt = 1'b1;
                if (led_cnt_r >= 32'(BLINK_ON - 1)) begin
                    led_st_nxt = LED_PAUSE;
                    led_cnt_nxt = '0;
                    led_on_nxt = 1'b0;
                end
            end
            // Long dark pause sets patterns apart
            LED_PAUSE: begin
                if (led_cnt_r >= 32'(PAUSE - 1)) begin
                    led_st_nxt = LED_IDLE;
                    led_cnt_nxt = '0;
                end
            end
        endcase
    end

    // Both colours together; no path back into motion control
    assign twin_colour_indicator_red = led_on_r;
    assign twin_colour_indicator_green = led_on_r;

    // Flag outputs straight from held flags
    assign user_watch_flag = flag_r[IDX_WATCH];
    assign deviation_notice_flag = flag_r[IDX_DEV];
    assign driver_heat_notice_flag = flag_r[IDX_DRV_HEAT];
    assign motor_heat_notice_flag = flag_r[IDX_MTR_HEAT];
    assign high_supply_notice_flag = flag_r[IDX_HIGH_SUP];
    assign low_supply_notice_flag = flag_r[IDX_LOW_SUP];
    assign overload_time_notice_flag = flag_r[IDX_OVL_TIME];
    assign speed_notice_flag = flag_r[IDX_SPEED];
    assign load_sum_a_notice_flag = flag_r[IDX_LOAD_A];
    assign load_sum_b_notice_flag = flag_r[IDX_LOAD_B];
    assign trip_distance_notice_flag = flag_r[IDX_TRIP];
    // Read data straight from its register
    assign reg_rdata = rdata_r;

    // State registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            // Settings back to their defaults
            ctrl_r <= CTRL_RST;
            action_r <= ACTION_RST;
            watch_sel_r <= SEL_W'(WATCH_SEL_RST);
            watch_inv_r <= 1'b0;
            dev_th_r <= DEV_TH_RST;
            drv_th_r <= DRV_TH_RST;
            mtr_th_r <= MTR_TH_RST;
            high_th_r <= HIGH_TH_AC_RST;
            low_th_r <= LOW_TH_AC_RST;
            ovl_th_r <= OVL_TH_RST;
            spd_th_r <= SPD_TH_RST;
            load_a_th_r <= LOAD_TH_RST;
            load_b_th_r <= LOAD_TH_RST;
            divisor_r <= DIVISOR_RST;
            trip_th_r <= TRIP_TH_RST;
            // Notices, load sum and blinking start cleared
            flag_r <= '0;
            load_sum_r <= '0;
            div_cnt_r <= '0;
            motion_d_r <= 1'b0;
            rdata_r <= '0;
            led_st_r <= LED_IDLE;
            led_cnt_r <= '0;
            led_on_r <= 1'b0;
        end else begin
            // Normal run: take every next value
            ctrl_r <= ctrl_nxt;
            action_r <= action_nxt;
            watch_sel_r <= watch_sel_nxt;
            watch_inv_r <= watch_inv_nxt;
            dev_th_r <= dev_th_nxt;
            drv_th_r <= drv_th_nxt;
            mtr_th_r <= mtr_th_nxt;
            high_th_r <= high_th_nxt;
            low_th_r <= low_th_nxt;
            ovl_th_r <= ovl_th_nxt;
            spd_th_r <= spd_th_nxt;
            load_a_th_r <= load_a_th_nxt;
            load_b_th_r <= load_b_th_nxt;
            divisor_r <= divisor_nxt;
            trip_th_r <= trip_th_nxt;
            flag_r <= flag_nxt;
            load_sum_r <= load_sum_nxt;
            div_cnt_r <= div_cnt_nxt;
            motion_d_r <= motion_d_nxt;
            rdata_r <= rdata_nxt;
            led_st_r <= led_st_nxt;
            led_cnt_r <= led_cnt_nxt;
            led_on_r <= led_on_nxt;
        end
    end

endmodule : predictive_notice_monitor

// [testbench/notice_monitor_monitor.sv]
// Checker module for the notice monitor ports, bound to the design
`timescale 1ns/10ps
module notice_monitor
    import notice_pkg::*;
#(
    parameter int SEL_W = 8
) (
    // Clock, reset and register port
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Watched measurements and outputs
    input wire logic [14:0] deviation,
    input wire logic [(1 << SEL_W)-1:0] watch_sources,
    input wire logic user_watch_flag,
    input wire logic deviation_notice_flag,
    input wire logic speed_notice_flag,
    input wire logic twin_colour_indicator_red,
    input wire logic twin_colour_indicator_green
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    logic [1:0] ctrl_r; // Shadow of auto clear and LED enable
    logic [8:0] watch_r; // Shadow of watch select and invert
    logic [14:0] dev_th_r; // Shadow of deviation threshold
    logic [13:0] spd_th_r; // Shadow of speed threshold
    logic watch_exp, dev_hit, clr_wr, mapped, red_q, second_r; // second_r: between blinks one and two
    // Shadows follow host writes on the same edge as the design
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= CTRL_RST[1:0];
            watch_r <= {1'b0, WATCH_SEL_RST};
            dev_th_r <= DEV_TH_RST;
            spd_th_r <= SPD_TH_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: ctrl_r <= reg_wdata[1:0];
                REG_WATCH: watch_r <= reg_wdata[8:0];
                REG_DEV_TH: dev_th_r <= reg_wdata[14:0];
                REG_SPD_TH: spd_th_r <= reg_wdata[13:0];
                default: ;
            endcase
        end
    end
    assign watch_exp = watch_sources[watch_r[7:0]] ^ watch_r[8];
    assign dev_hit = deviation >= dev_th_r;
    assign clr_wr = reg_wr && reg_addr == REG_CLEAR;
    // Write-only clear reads back as unmapped
    assign mapped = reg_addr <= REG_LOAD_SUM && reg_addr[1:0] == 2'b00;
    // Pattern parity: a started pattern finishes even if the LED is disabled
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            red_q <= 1'b0;
            second_r <= 1'b0;
        end else begin
            red_q <= twin_colour_indicator_red;
            if (twin_colour_indicator_red && !red_q) begin
                second_r <= !second_r;
            end
        end
    end
    a_watch_follow: assert property ($past(rst_n) && $past(ctrl_r[0]) |-> user_watch_flag == $past(watch_exp))
        else $error("watch flag wrong");
    a_dev_raise: assert property (dev_hit |=> deviation_notice_flag)
        else $error("deviation flag not raised");
    a_auto_drop: assert property (ctrl_r[0] && !dev_hit |=> !deviation_notice_flag)
        else $error("deviation flag not dropped");
    a_held_flag: assert property (!ctrl_r[0] && deviation_notice_flag && !clr_wr |=> deviation_notice_flag)
        else $error("held flag lost");
    a_speed_off: assert property (spd_th_r == 14'h0 && ctrl_r[0] |=> !speed_notice_flag)
        else $error("speed flag with zero threshold");
    a_led_twin: assert property (twin_colour_indicator_red == twin_colour_indicator_green)
        else $error("lamp colours differ");
    a_led_gate: assert property ($rose(twin_colour_indicator_red) && !second_r |-> $past(ctrl_r[1], 2))
        else $error("lamp lit while disabled");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    a_unmapped_zero: assert property ($past(reg_rd) && !$past(mapped) |-> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    c_blink: cover property ($rose(twin_colour_indicator_red));
    c_held: cover property (!ctrl_r[0] && deviation_notice_flag && !dev_hit);
    c_watch: cover property ($rose(user_watch_flag));
endmodule : notice_monitor

bind predictive_notice_monitor notice_monitor #(.SEL_W(SEL_W)) u_mon (.*);

// [testbench/host_model.sv]
// Host side watcher that counts indicator blinks
`timescale 1ns/10ps
module host_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Indicator seen by the host
    input wire logic led_red,
    input wire logic led_green,
    // Blinks seen so far
    output int blink_cnt
);
    logic led_q; // Lamp level last cycle
    // A blink counts only when both colours light together
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            led_q <= 1'b0;
            blink_cnt <= 0;
        end else begin
            led_q <= led_red;
            if (led_red && led_green && !led_q) begin
                blink_cnt <= blink_cnt + 1;
            end
        end
    end
endmodule : host_model

// [testbench/tb_top.sv]
// Self-checking bench for the notice monitor
`timescale 1ns/10ps
module tb_top;
    import notice_pkg::*;
    logic clk_sys, rst_n, reg_wr, reg_rd, load_sample_vld, motion_active, led_red, led_green;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [14:0] deviation;
    logic [6:0] driver_temp, motor_temp;
    logic [9:0] supply_volt;
    logic [8:0] overload_time;
    logic [13:0] motor_speed;
    logic [15:0] load_sample;
    logic [30:0] trip_distance;
    logic [255:0] watch_sources; // Bit 128 stays low: constant-off source
    int error_cnt, samples_checked, blink_cnt, b0;
    int defs [14] = '{15, 2047, 128, 300, 85, 85, 435, 120, 50, 0, 0, 0, 1, 0}; // Reset values
    int idx [8] = '{1, 2, 3, 4, 5, 6, 7, 10};
    int hit [8] = '{300, 85, 85, 630, 180, 50, 1000, 5};
    int miss [8] = '{299, 84, 84, 629, 181, 49, 999, 4}; // One step short
    int rest [8] = '{0, 0, 0, 200, 200, 0, 0, 0};
    // Short blink timings keep the run brief
    predictive_notice_monitor #(.BLINK_ON(3), .BLINK_OFF(3), .PAUSE(8)) uut (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .deviation, .driver_temp, .motor_temp, .supply_volt, .overload_time, .motor_speed,
        .load_sample, .load_sample_vld, .trip_distance, .motion_active, .watch_sources,
        .user_watch_flag(), .deviation_notice_flag(), .driver_heat_notice_flag(),
        .motor_heat_notice_flag(), .high_supply_notice_flag(), .low_supply_notice_flag(),
        .overload_time_notice_flag(), .speed_notice_flag(), .load_sum_a_notice_flag(),
        .load_sum_b_notice_flag(), .trip_distance_notice_flag(), .notice_out(),
        .twin_colour_indicator_red(led_red), .twin_colour_indicator_green(led_green));
    host_model u_host (.clk_sys, .rst_n, .led_red, .led_green, .blink_cnt);
    // 50 ns clock
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // Write: one strobe cycle, then a quiet edge so strobes never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        cyc(1);
        reg_wr <= 1'b0;
        cyc(1);
    endtask : wr
    // Read: data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        cyc(1);
        reg_rd <= 1'b0;
        #1 chk($sformatf("reg %h", a), e, reg_rdata);
        cyc(1);
    endtask : rd
    task automatic set_q(input int i, input int v);
        case (i)
            1: deviation <= 15'(v);
            2: driver_temp <= 7'(v);
            3: motor_temp <= 7'(v);
            4, 5: supply_volt <= 10'(v);
            6: overload_time <= 9'(v);
            7: motor_speed <= 14'(v);
            default: trip_distance <= 31'(v);
        endcase
    endtask : set_q
    task automatic results();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : results
    // Watchdog well past the expected run length
    initial begin
        #(50 * 5000);
        error_cnt++;
        results();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, load_sample_vld, motion_active, reg_addr, reg_wdata} = '0;
        {deviation, driver_temp, motor_temp, overload_time, motor_speed, load_sample} = '0;
        trip_distance = '0;
        watch_sources = '0;
        supply_volt = 10'd200;
        error_cnt = 0;
        samples_checked = 0;
        cyc(2);
        rst_n <= 1'b1;
        cyc(1);
        for (int i = 0; i < 14; i++) rd(8'(4 * i), 32'(defs[i]));
        rd(REG_STATUS, 32'hb00);
        rd(8'h44, 32'h0);
        rd(REG_CLEAR, 32'h0);
        wr(REG_DIVISOR, 32'h0);
        rd(REG_DIVISOR, 32'h1);
        wr(REG_HIGH_TH, 32'd630);
        wr(REG_LOW_TH, 32'd180);
        rd(REG_HIGH_TH, 32'd630);
        wr(REG_LOAD_A_TH, 32'd1000);
        wr(REG_LOAD_B_TH, 32'd2000);
        set_q(7, 1000);
        rd(REG_STATUS, 32'h0);
        wr(REG_SPD_TH, 32'd1000);
        wr(REG_TRIP_TH, 32'd5);
        set_q(7, 0);
        // Each notice in idx: one step short stays quiet, the threshold raises it
        for (int k = 0; k < 8; k++) begin
            set_q(idx[k], miss[k]);
            cyc(2);
            rd(REG_STATUS, 32'h0);
            set_q(idx[k], hit[k]);
            cyc(2);
            rd(REG_STATUS, 32'h800 | (32'h1 << idx[k]));
            set_q(idx[k], rest[k]);
            cyc(1);
        end
        cyc(30);
        b0 = blink_cnt;
        wr(REG_ACTION, 32'h7fd);
        set_q(1, 300);
        cyc(30);
        rd(REG_STATUS, 32'h002);
        chk("blinks", 32'(b0), 32'(blink_cnt));
        wr(REG_ACTION, 32'h7ff);
        cyc(3);
        set_q(1, 0);
        cyc(30);
        chk("blinks", 32'(b0 + 2), 32'(blink_cnt));
        wr(REG_CTRL, 32'hd);
        set_q(1, 300);
        cyc(30);
        chk("blinks", 32'(b0 + 2), 32'(blink_cnt));
        set_q(1, 0);
        // Held flags without auto clear; a clear with cause present loses
        wr(REG_CTRL, 32'hc);
        cyc(2);
        set_q(1, 300);
        cyc(2);
        set_q(1, 0);
        cyc(2);
        rd(REG_STATUS, 32'h802);
        set_q(1, 300);
        wr(REG_CLEAR, 32'h1);
        rd(REG_STATUS, 32'h802);
        set_q(1, 0);
        cyc(2);
        wr(REG_CLEAR, 32'h1);
        rd(REG_STATUS, 32'h0);
        wr(REG_CTRL, 32'hf);
        watch_sources[5] <= 1'b1;
        wr(REG_WATCH, 32'h5);
        rd(REG_STATUS, 32'h801);
        wr(REG_WATCH, 32'h105);
        rd(REG_STATUS, 32'h0);
        wr(REG_WATCH, 32'h180);
        rd(REG_STATUS, 32'h801);
        wr(REG_WATCH, 32'h80);
        // Load sum: divisor 2 keeps one sample in two
        wr(REG_DIVISOR, 32'h2);
        load_sample <= 16'd10;
        load_sample_vld <= 1'b1;
        cyc(4);
        load_sample_vld <= 1'b0;
        rd(REG_LOAD_SUM, 32'd20);
        wr(REG_LOAD_A_TH, 32'd20);
        rd(REG_STATUS, 32'h900);
        motion_active <= 1'b1;
        cyc(2);
        rd(REG_LOAD_SUM, 32'h0);
        motion_active <= 1'b0;
        wr(REG_CTRL, 32'hb);
        load_sample_vld <= 1'b1;
        cyc(4);
        load_sample_vld <= 1'b0;
        motion_active <= 1'b1;
        cyc(2);
        rd(REG_LOAD_SUM, 32'd20);
        results();
    end
endmodule : tb_top
